/* verilog/mpc_consts.svh */
// constants of the multi-purpose pin configuration block
// assumes inclusion by the package, mpc_pin_config and the bench
//
// What this block does
// - field picks input, inverted input, low, high
// - pin n field sits at bits 2n+1:2n
// - parallel mode forces pin 0 to output
// - nonzero power-down filter forces pin 1 output
// - wake enable makes pin 2 set status
// - bit 4 sets wake input polarity
// - software reads the two mode pins
// - filter field 00 disables power-down claim
// - wake enable low blocks status setting
`ifndef MPC_CONSTS_SVH
`define MPC_CONSTS_SVH
`define MPC_CFG_OFFSET 8'h04
`define MPC_CFG_RESET 32'h0000_0000
`define MPC_CFG_USED_MASK 32'h00FF_FFFF
`define MPC_FIELD_W 2
`define MPC_MODE_PARALLEL 2'h1
`define MPC_PDF_OFF 2'h0
`define MPC_PDF_LSB 5
`define MPC_WAKE_EN_BIT 7
`define MPC_WAKE_POL_BIT 4
`endif

/* verilog/mpc_pkg.sv */
// types of the multi-purpose pin configuration block
// assumes mpc_consts.svh beside it
`include "mpc_consts.svh"
package mpc_pkg;
  // per-pin function codes
  typedef enum logic [1:0] {
    MPC_IN_PLAIN = 2'h0,
    MPC_IN_INV = 2'h1,
    MPC_OUT_LOW = 2'h2,
    MPC_OUT_HIGH = 2'h3
  } mpc_func_t;

  // register access strobe bundle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } mpc_req_t;

  // whole state of the top module
  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] rdata;
    logic rvalid;
    logic [11:0] pin_out;
    logic [11:0] pin_oe;
    logic [11:0] pin_level;
    logic wake_set;
    logic [1:0] mode;
  } mpc_state_t;
endpackage

/* verilog/mpc_pin_cell.sv */
// one multi-purpose pin: decodes its 2-bit field into drive and input level
// assumes the caller applies any output overrides via force_out_in
module mpc_pin_cell
  import mpc_pkg::*;
(
  input wire logic [1:0] field_in,
  input wire logic force_out_in,
  input wire logic force_level_in,
  input wire logic pin_in,
  output logic drive_out,
  output logic oe_out,
  output logic level_out
);
  // ****************************************
  // field decode
  // ****************************************
  // field selects function
  always_comb begin
    drive_out = 1'b0;
    oe_out = 1'b0;
    level_out = pin_in;
    if (force_out_in) begin
      oe_out = 1'b1;
      drive_out = force_level_in;
    end else begin
      unique case (mpc_func_t'(field_in))
        MPC_IN_PLAIN: level_out = pin_in;
        MPC_IN_INV: level_out = ~pin_in;
        MPC_OUT_LOW: begin
          oe_out = 1'b1;
          drive_out = 1'b0;
        end
        MPC_OUT_HIGH: begin
          oe_out = 1'b1;
          drive_out = 1'b1;
        end
      endcase
    end
  end
endmodule

/* verilog/mpc_pin_config.sv */
// multi-purpose pin configuration register and twelve pin cells
// assumes a decoded register strobe from the host target logic, synchronous inputs
`include "mpc_consts.svh"
module mpc_pin_config
  import mpc_pkg::*;
#(
  parameter int PINS = 12
)
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic cfg_load_in,
  input wire logic [31:0] cfg_load_data_in,
  input wire logic [1:0] mode_pins_in,
  input wire logic [7:0] local_config_control_in,
  input wire logic pp_pin0_level_in,
  input wire logic pd_pin1_level_in,
  input wire logic [11:0] general_pin_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic [1:0] mode_out,
  output logic [11:0] general_pin_out,
  output logic [11:0] general_pin_oe_out,
  output logic [11:0] general_pin_level_out,
  output logic wake_status_set_out
);
  // refuse every pin count other than the 12 that the fixed 2-bit field map holds
  if (PINS != 12) begin : g_bad_pins
    $error("mpc_pin_config supports exactly 12 pins");
  end

  // ****************************************
  // state and pin decode
  // ****************************************
  mpc_state_t s_q, s_d;
  mpc_req_t req;
  logic [11:0] drv, oe, lvl, force_out, force_lvl;
  logic pd_on, wake_en, wake_hit;
  logic [23:0] field;

  // field of pin n within a configuration word
  function automatic logic [1:0] pin_field(input logic [31:0] word, input int n);
    return word[2*n +: `MPC_FIELD_W];
  endfunction

  assign req = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};
  // filter 00 leaves pin 1 free
  assign pd_on = local_config_control_in[`MPC_PDF_LSB +: 2] != `MPC_PDF_OFF;
  assign wake_en = local_config_control_in[`MPC_WAKE_EN_BIT];

  // pin ownership by other functions
  always_comb begin
    force_out = '0;
    force_lvl = '0;
    force_out[0] = s_q.mode == `MPC_MODE_PARALLEL;
    force_lvl[0] = pp_pin0_level_in;
    force_out[1] = pd_on;
    force_lvl[1] = pd_pin1_level_in;
    // wake input keeps pin 2 an input
    force_out[2] = 1'b0;
  end

  // field seen by each pin cell; pin 2 as wake input ignores its output-enable bit
  always_comb begin
    field = s_q.cfg[23:0];
    // wake enable turns pin 2 into an input
    if (wake_en) begin
      field[5:4] = {1'b0, s_q.cfg[`MPC_WAKE_POL_BIT]};
    end
  end

  genvar g;
  generate
    for (g = 0; g < 12; g++) begin : g_pin
      // field of pin g at bits 2g+1:2g
      mpc_pin_cell u_cell (
        .field_in(field[2*g +: `MPC_FIELD_W]),
        .force_out_in(force_out[g]),
        .force_level_in(force_lvl[g]),
        .pin_in(general_pin_in[g]),
        .drive_out(drv[g]),
        .oe_out(oe[g]),
        .level_out(lvl[g])
      );
    end
  endgenerate

  // bit 4 picks wake polarity; enable gates it
  assign wake_hit = wake_en && (general_pin_in[2] ^ s_q.cfg[`MPC_WAKE_POL_BIT]);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.mode = mode_pins_in;
    if (cfg_load_in) begin
      s_d.cfg = cfg_load_data_in & `MPC_CFG_USED_MASK;
    end else if (req.wr && req.addr == `MPC_CFG_OFFSET) begin
      s_d.cfg = req.wdata & `MPC_CFG_USED_MASK;
    end
    if (req.rd) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = (req.addr == `MPC_CFG_OFFSET) ? (s_q.cfg & `MPC_CFG_USED_MASK) : 32'h0000_0000;
    end
    s_d.pin_out = drv;
    s_d.pin_oe = oe;
    s_d.pin_level = lvl;
    // registered level that sets function 1 status, high for as long as the wake input stays active
    s_d.wake_set = wake_hit;
  end

  // reset makes every pin a plain input
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_q <= '{cfg: `MPC_CFG_RESET, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_out = s_q.rdata;
  assign reg_rvalid_out = s_q.rvalid;
  assign mode_out = s_q.mode;
  assign general_pin_out = s_q.pin_out;
  assign general_pin_oe_out = s_q.pin_oe;
  assign general_pin_level_out = s_q.pin_level;
  assign wake_status_set_out = s_q.wake_set;

  // ****************************************
  // assertions
  // ****************************************
  // host write of the configuration word
  sequence s_cfg_write;
    reg_wr_in && !cfg_load_in && reg_addr_in == `MPC_CFG_OFFSET;
  endsequence

  // loader store of the configuration word
  sequence s_cfg_load;
    cfg_load_in;
  endsequence

  // host read of the configuration word with no store in the same cycle
  sequence s_cfg_read;
    reg_rd_in && !reg_wr_in && !cfg_load_in && reg_addr_in == `MPC_CFG_OFFSET;
  endsequence

  a_reserved_zero: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    reg_rvalid_out |-> reg_rdata_out[31:24] == 8'h00) else $error("reserved bits not zero");
  a_write_lands: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    s_cfg_write ##1 s_cfg_read |=> reg_rdata_out[23:0] == $past(reg_wdata_in[23:0], 2))
    else $error("write not read back");
  a_load_lands: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    s_cfg_load ##1 s_cfg_read |=> reg_rdata_out[23:0] == $past(cfg_load_data_in[23:0], 2))
    else $error("load not read back");
  a_other_zero: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    reg_rd_in && reg_addr_in != `MPC_CFG_OFFSET |=> reg_rvalid_out && reg_rdata_out == 32'h0000_0000)
    else $error("other offset not zero");
  a_out_high: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    s_q.cfg[7:6] == 2'h3 |=> general_pin_oe_out[3] && general_pin_out[3]) else $error("pin 3 not high");
  a_out_low: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    pin_field(s_q.cfg, 5) == MPC_OUT_LOW |=> general_pin_oe_out[5] && !general_pin_out[5]) else $error("pin 5 not low");
  a_inv_input: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    s_q.cfg[9:8] == 2'h1 |=> general_pin_level_out[4] == !$past(general_pin_in[4])) else $error("pin 4 not inverted");
  a_plain_input: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    pin_field(s_q.cfg, 6) == MPC_IN_PLAIN |=> !general_pin_oe_out[6]
    && general_pin_level_out[6] == $past(general_pin_in[6])) else $error("pin 6 not plain input");
  a_parallel_pin: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    s_q.mode == 2'h1 |=> general_pin_oe_out[0]) else $error("pin 0 not forced");
  // pin 0 carries the port level
  a_parallel_level: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    s_q.mode == `MPC_MODE_PARALLEL |=> general_pin_out[0] == $past(pp_pin0_level_in)) else $error("pin 0 level wrong");
  a_pd_pin: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    local_config_control_in[6:5] != 2'h0 |=> general_pin_oe_out[1]) else $error("pin 1 not forced");
  // pin 1 carries the power-down level
  a_pd_level: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    local_config_control_in[6:5] != 2'h0 |=> general_pin_out[1] == $past(pd_pin1_level_in)) else $error("pin 1 level wrong");
  // filter off leaves pin 1 free
  a_pd_off: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    local_config_control_in[6:5] == 2'h0 && s_q.cfg[3:2] == 2'h0 |=> !general_pin_oe_out[1])
    else $error("pin 1 claimed while off");
  a_pd_free: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    local_config_control_in[6:5] == 2'h0 && pin_field(s_q.cfg, 1) == MPC_OUT_HIGH
    |=> general_pin_oe_out[1] && general_pin_out[1]) else $error("pin 1 field ignored");
  a_wake_input: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    local_config_control_in[7] |=> !general_pin_oe_out[2]) else $error("wake pin driven");
  a_wake_pol: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    local_config_control_in[7] && (general_pin_in[2] != s_q.cfg[4]) |=> wake_status_set_out)
    else $error("wake polarity wrong");
  a_wake_quiet: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    local_config_control_in[7] && (general_pin_in[2] == s_q.cfg[4]) |=> !wake_status_set_out)
    else $error("wake set at idle level");
  // wake pin level follows polarity bit
  a_wake_level: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    local_config_control_in[7] |=> general_pin_level_out[2] == ($past(general_pin_in[2]) ^ $past(s_q.cfg[4])))
    else $error("wake pin level wrong");
  a_wake_block: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !local_config_control_in[7] |=> !wake_status_set_out) else $error("wake set while disabled");
  a_mode_read: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    1'b1 |=> mode_out == $past(mode_pins_in)) else $error("mode readback wrong");
endmodule

/* verif/mpc_board.sv */
// board around the pins: pins the block does not drive take random levels
// assumes the bench pulses step_in to pick new levels for the undriven pins
module mpc_board (
  input wire logic clk_in,
  input wire logic step_in,
  input wire logic [11:0] drv_in,
  input wire logic [11:0] oe_in,
  output logic [11:0] pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] ext_q = 12'h0;
  // new floating levels only when asked, so checks see stable inputs
  always @(negedge clk_in) begin
    if (step_in) ext_q <= 12'($urandom);
  end
  // driven pins show the block's drive, the rest show the board
  assign pin_out = (oe_in & drv_in) | (~oe_in & ext_q);
endmodule

/* verif/mpc_pin_config_bench.sv */
// self-checking bench of the pin configuration block
// assumes the design files and mpc_board compiled first
`include "mpc_consts.svh"
module mpc_pin_config_bench
  import mpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, arst_n_in = 0, wr = 0, rd = 0, ld = 0, pp = 0, pd = 0, step = 0, rv, wake;
  logic [7:0] addr = 8'h04, local_config_control = 8'h00;
  logic [31:0] wd = 32'h0, cfg = 32'h0, rdat;
  logic [1:0] mode = 2'h0, mode_o;
  logic [11:0] pin, pout, poe, plvl;
  logic [31:0] exp_q[$];
  int n_errors = 0, cmp_count = 0;
  mpc_pin_config dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wd), .cfg_load_in(ld), .cfg_load_data_in(wd), .mode_pins_in(mode),
    .local_config_control_in(local_config_control), .pp_pin0_level_in(pp), .pd_pin1_level_in(pd), .general_pin_in(pin),
    .reg_rdata_out(rdat), .reg_rvalid_out(rv), .mode_out(mode_o), .general_pin_out(pout),
    .general_pin_oe_out(poe), .general_pin_level_out(plvl), .wake_status_set_out(wake));
  mpc_board board (.clk_in(clk_in), .step_in(step), .drv_in(pout), .oe_in(poe), .pin_out(pin));
  initial forever #2.5 clk_in = ~clk_in;
  // ****************************************
  // tasks
  // ****************************************
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask
  // write by bus, or by loader when l is set
  task automatic wr_reg(logic [7:0] a, logic [31:0] d, logic l);
    @(negedge clk_in);
    addr = a;
    wd = d;
    wr = !l;
    ld = l;
    @(negedge clk_in);
    wr = 0;
    ld = 0;
    if (l || a == `MPC_CFG_OFFSET) cfg = d & `MPC_CFG_USED_MASK;
  endtask
  // read and note the expected word for the monitor
  task automatic rd_reg(logic [7:0] a);
    @(negedge clk_in);
    addr = a;
    rd = 1;
    exp_q.push_back(a == `MPC_CFG_OFFSET ? cfg : 32'h0);
    @(negedge clk_in);
    rd = 0;
  endtask
  // write or load the word, then read it back in the very next cycle
  task automatic wr_rd(logic [31:0] d, logic l);
    @(negedge clk_in);
    addr = `MPC_CFG_OFFSET;
    wd = d;
    wr = !l;
    ld = l;
    @(negedge clk_in);
    wr = 0;
    ld = 0;
    rd = 1;
    cfg = d & `MPC_CFG_USED_MASK;
    exp_q.push_back(cfg);
    @(negedge clk_in);
    rd = 0;
  endtask
  // expected pin state from the field table and the overrides
  task automatic chk_pins();
    logic [11:0] eo, ed, el;
    for (int n = 0; n < 12; n++) begin
      eo[n] = cfg[2*n+1];
      ed[n] = cfg[2*n];
      el[n] = pin[n] ^ cfg[2*n];
    end
    if (mode == `MPC_MODE_PARALLEL) {eo[0], ed[0]} = {1'b1, pp};
    if (local_config_control[6:5] != `MPC_PDF_OFF) {eo[1], ed[1]} = {1'b1, pd};
    if (local_config_control[7]) eo[2] = 1'b0;
    cmp("oe", 32'(eo), 32'(poe));
    cmp("drive", 32'(ed & eo), 32'(pout & eo));
    cmp("level", 32'(el & ~eo), 32'(plvl & ~eo));
    cmp("wake", 32'(local_config_control[7] & (pin[2] ^ cfg[4])), 32'(wake));
    cmp("mode", 32'(mode), 32'(mode_o));
  endtask
  task automatic give_verdict();
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ****************************************
  // monitor and sequence
  // ****************************************
  // read results are matched against the oldest note
  always @(negedge clk_in) begin
    if (rv === 1'b1) cmp("rdata", exp_q.size() > 0 ? exp_q.pop_front() : 32'hDEAD_BEEF, rdat);
  end
  initial begin
    void'($urandom(32'hA447BF00));
    repeat (20) @(negedge clk_in);
    cmp("reset oe", 32'h0, 32'(poe));
    arst_n_in = 1;
    rd_reg(8'h04);
    for (int i = 0; i < 200; i++) begin
      mode = 2'($urandom);
      local_config_control = 8'($urandom);
      pp = 1'($urandom);
      pd = 1'($urandom);
      step = 1;
      wr_reg(i % 5 == 0 ? 8'h08 : 8'h04, $urandom, i % 4 == 0);
      step = 0;
      repeat (4) @(negedge clk_in);
      chk_pins();
      rd_reg(i[0] ? 8'h04 : 8'h10);
      if (i % 8 == 3) wr_rd($urandom, i % 16 == 11);
    end
    repeat (4) @(negedge clk_in);
    // second reset at the end of the run: pins fall back to inputs and the word to its reset value
    arst_n_in = 0;
    repeat (3) @(negedge clk_in);
    cmp("reset oe", 32'h0, 32'(poe));
    arst_n_in = 1;
    cfg = `MPC_CFG_RESET;
    rd_reg(`MPC_CFG_OFFSET);
    repeat (4) @(negedge clk_in);
    cmp("pending", 32'h0, 32'(exp_q.size()));
    give_verdict();
  end
  // watchdog far beyond the expected run of some 1700 cycles
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
endmodule
